// [rtl/psl_pkg.sv]
// Contract
// - Every rising serial clock edge shifts the serial data level into a 32-bit shift register.
// - Words arrive most significant bit first and the last three bits name the destination.
// - A rising load strobe copies the shift register into the register the three low bits name.
// - Chip enable low powers the device down and floats the pump output.
// - Chip enable high powers up only as far as the programmed power-down bit allows.
// - A low rf_mute_n pin or the software enable bit mutes both RF outputs.
// - The lock indicator is high while locked and low once lock is lost.
// - The selectable test output shows lock, the divided feedback or the divided reference.
// - The RF pair carries the oscillator undivided or divided, at a programmed level.
// - Codes 000 to 101 in bits 2 to 0 select registers 0 to 5.
// - Double-buffered settings take effect only on a following write to register 0.
package psl_pkg;

	localparam int WORD_W = 32;
	localparam int NUM_REGS = 6;
	localparam int IRQ_W = 4;

	// Latch codes
	localparam logic [2:0] CODE_R0 = 3'h0;
	localparam logic [2:0] CODE_R4 = 3'h4;
	localparam logic [2:0] CODE_MAX = 3'h5;

	// Field positions inside the latched words
	localparam int R2_PD_BIT = 5;
	localparam int R2_DBUF_DIV_BIT = 13;
	localparam int R2_MUX_LSB = 26;
	localparam int R4_LEVEL_LSB = 3;
	localparam int R4_RF_EN_BIT = 5;
	localparam int R4_MTLD_BIT = 10;
	localparam int R4_DIV_LSB = 20;

	// Test output selections
	localparam logic [2:0] MUX_TRISTATE = 3'h0;
	localparam logic [2:0] MUX_HIGH = 3'h1;
	localparam logic [2:0] MUX_LOW = 3'h2;
	localparam logic [2:0] MUX_REF_DIV = 3'h3;
	localparam logic [2:0] MUX_FB_DIV = 3'h4;
	localparam logic [2:0] MUX_ALOCK = 3'h5;
	localparam logic [2:0] MUX_DLOCK = 3'h6;

	// Avalon byte addresses
	localparam logic [7:0] ADDR_SHADOW0 = 8'h00;
	localparam logic [7:0] ADDR_ACT_R1 = 8'h18;
	localparam logic [7:0] ADDR_ACT_R2 = 8'h1c;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_ENABLE = 8'h24;
	localparam logic [7:0] ADDR_CLEAR = 8'h28;
	localparam logic [7:0] ADDR_PINS = 8'h2c;
	localparam logic [7:0] ADDR_SHIFT = 8'h30;

	// Interrupt bits
	localparam int EV_LATCH = 0;
	localparam int EV_BAD_CODE = 1;
	localparam int EV_LOCK_GAIN = 2;
	localparam int EV_LOCK_LOSS = 3;

	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [3:0] IRQ_RESET = 4'h0;

	typedef logic [WORD_W-1:0] psl_word_t;
	typedef logic [NUM_REGS-1:0][WORD_W-1:0] psl_bank_t;

	typedef struct packed {
		logic sclk_s1, sclk_s2, sclk_d;
		logic sdat_s1, sdat_s2;
		logic le_s1, le_s2, le_d;
		logic ce_s1, ce_s2;
		logic mute_s1, mute_s2;
		logic lock_s1, lock_s2, lock_d;
		logic ref_s1, ref_s2;
		logic fb_s1, fb_s2;
		logic vco_s1, vco_s2, vco_d;
		psl_word_t shift;
		psl_bank_t shadow;
		psl_word_t act_r1;
		psl_word_t act_r2;
		logic [2:0] div_sel;
		logic [3:0] div_cnt;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_enable;
		logic bus_ack;
		psl_word_t readdata;
		logic rf_p, rf_n;
		logic [1:0] rf_level;
		logic mux_out, mux_oe;
		logic lock_out;
		logic pump_oe;
		logic powered;
	} psl_state_t;

endpackage : psl_pkg

// [rtl/psl_core.sv]
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module psl_core (
	input  wire logic              clock,
	input  wire logic              arst_n,
	// Serial load pins, asynchronous to clock
	input  wire logic              serial_clk,
	input  wire logic              serial_data,
	input  wire logic              load_strobe,
	// Control pins
	input  wire logic              chip_enable,
	input  wire logic              rf_mute_n,
	// Loop status from the analog side
	input  wire logic              loop_locked,
	input  wire logic              ref_div_in,
	input  wire logic              fb_div_in,
	input  wire logic              vco_in,
	// Pins out
	output logic                   lock_indicator,
	output logic                   selectable_test_output,
	output logic                   selectable_test_output_oe,
	output logic                   pump_output_oe,
	output logic                   powered_up,
	output logic                   rf_out_p,
	output logic                   rf_out_n,
	output logic [1:0]             rf_out_level,
	output psl_pkg::psl_bank_t     active_words,
	// Avalon-MM slave
	input  wire logic [7:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	output logic                   irq
);

	psl_pkg::psl_state_t r_reg;
	psl_pkg::psl_state_t r_next;

	logic       sclk_rise;
	logic       le_rise;
	logic       vco_rise;
	logic [2:0] code;
	logic       code_ok;
	logic       bus_req;
	logic       bus_fire;

	localparam int IRQ_W_LOCAL = psl_pkg::IRQ_W;
	localparam int EV_LATCH_LOCAL = psl_pkg::EV_LATCH;
	localparam int EV_BAD_CODE_LOCAL = psl_pkg::EV_BAD_CODE;
	localparam int EV_LOCK_GAIN_LOCAL = psl_pkg::EV_LOCK_GAIN;
	localparam int EV_LOCK_LOSS_LOCAL = psl_pkg::EV_LOCK_LOSS;

	// Maps a readable byte address to its data; unmapped reads return zero
	function automatic psl_pkg::psl_word_t read_mux(
		input logic [7:0]            addr,
		input psl_pkg::psl_state_t   s
	);
		psl_pkg::psl_word_t d;
		d = psl_pkg::WORD_RESET;
		if (addr < psl_pkg::ADDR_ACT_R1 && addr[1:0] == 2'h0) begin
			d = s.shadow[addr[4:2]];
		end else begin
			unique case (addr)
				psl_pkg::ADDR_ACT_R1: d = s.act_r1;
				psl_pkg::ADDR_ACT_R2: d = s.act_r2;
				psl_pkg::ADDR_STATUS: d = {28'h000_0000, s.irq_status};
				psl_pkg::ADDR_ENABLE: d = {28'h000_0000, s.irq_enable};
				psl_pkg::ADDR_PINS: d = {26'h000_0000, s.powered, s.pump_oe,
					s.lock_s2, s.mute_s2, s.ce_s2, s.le_s2};
				psl_pkg::ADDR_SHIFT: d = s.shift;
				default: d = psl_pkg::WORD_RESET;
			endcase
		end
		return d;
	endfunction : read_mux

	// Picks the divided oscillator tap; selections above 4 clamp to the deepest
	function automatic logic div_tap(
		input logic [2:0] sel,
		input logic [3:0] cnt,
		input logic       vco
	);
		logic t;
		t = vco;
		unique case (sel)
			3'h0: t = vco;
			3'h1: t = cnt[0];
			3'h2: t = cnt[1];
			3'h3: t = cnt[2];
			default: t = cnt[3];
		endcase
		return t;
	endfunction : div_tap

	// Edge finders look only at second stages and their delayed copies
	assign sclk_rise = r_reg.sclk_s2 & ~r_reg.sclk_d;
	assign le_rise = r_reg.le_s2 & ~r_reg.le_d;
	assign vco_rise = r_reg.vco_s2 & ~r_reg.vco_d;
	assign code = r_reg.shift[2:0];
	assign code_ok = code <= psl_pkg::CODE_MAX;
	assign bus_req = avs_read | avs_write;
	assign bus_fire = bus_req & r_reg.bus_ack;

	always_comb begin
		logic [IRQ_W_LOCAL-1:0] ev;
		logic [2:0]             mux_sel;
		logic                   rf_on;
		logic                   rf_src;
		psl_pkg::psl_word_t     r2_sh;
		psl_pkg::psl_word_t     r4_sh;
		ev = '0;
		mux_sel = 3'h0;
		rf_on = 1'b0;
		rf_src = 1'b0;
		r2_sh = r_reg.shadow[2];
		r4_sh = r_reg.shadow[4];
		r_next = r_reg;

		// Two-flop synchronisers for every pin
		r_next.sclk_s1 = serial_clk;
		r_next.sclk_s2 = r_reg.sclk_s1;
		r_next.sclk_d = r_reg.sclk_s2;
		r_next.sdat_s1 = serial_data;
		r_next.sdat_s2 = r_reg.sdat_s1;
		r_next.le_s1 = load_strobe;
		r_next.le_s2 = r_reg.le_s1;
		r_next.le_d = r_reg.le_s2;
		r_next.ce_s1 = chip_enable;
		r_next.ce_s2 = r_reg.ce_s1;
		r_next.mute_s1 = rf_mute_n;
		r_next.mute_s2 = r_reg.mute_s1;
		r_next.lock_s1 = loop_locked;
		r_next.lock_s2 = r_reg.lock_s1;
		r_next.lock_d = r_reg.lock_s2;
		r_next.ref_s1 = ref_div_in;
		r_next.ref_s2 = r_reg.ref_s1;
		r_next.fb_s1 = fb_div_in;
		r_next.fb_s2 = r_reg.fb_s1;
		r_next.vco_s1 = vco_in;
		r_next.vco_s2 = r_reg.vco_s1;
		r_next.vco_d = r_reg.vco_s2;

		// Data sampled at the synchronised edge; serial clock period must span
		// several system clocks, which the pin timing limits guarantee
		if (sclk_rise) begin
			r_next.shift = {r_reg.shift[30:0], r_reg.sdat_s2};
		end

		if (le_rise) begin
			if (code_ok) begin
				ev[EV_LATCH_LOCAL] = 1'b1;
				r_next.shadow[code] = r_reg.shift;
				if (code == psl_pkg::CODE_R0) begin
					// Buffered settings move over only now
					r_next.act_r1 = r_reg.shadow[1];
					r_next.act_r2 = r2_sh;
					if (r2_sh[psl_pkg::R2_DBUF_DIV_BIT]) begin
						r_next.div_sel = r4_sh[psl_pkg::R4_DIV_LSB +: 3];
					end
				end
				if (code == psl_pkg::CODE_R4 && !r2_sh[psl_pkg::R2_DBUF_DIV_BIT]) begin
					r_next.div_sel = r_reg.shift[psl_pkg::R4_DIV_LSB +: 3];
				end
			end else begin
				ev[EV_BAD_CODE_LOCAL] = 1'b1;
			end
		end

		// Power state follows the pin and the programmed power-down bit
		r_next.powered = r_reg.ce_s2 & ~r2_sh[psl_pkg::R2_PD_BIT];
		r_next.pump_oe = r_next.powered;

		r_next.lock_out = r_reg.lock_s2;
		ev[EV_LOCK_GAIN_LOCAL] = r_reg.lock_s2 & ~r_reg.lock_d;
		ev[EV_LOCK_LOSS_LOCAL] = ~r_reg.lock_s2 & r_reg.lock_d;

		// Oscillator model: rate is bounded by sampling at the system clock
		if (vco_rise) begin
			r_next.div_cnt = r_reg.div_cnt + 4'h1;
		end
		rf_on = r_reg.powered & r_reg.mute_s2 & r4_sh[psl_pkg::R4_RF_EN_BIT]
			& (~r4_sh[psl_pkg::R4_MTLD_BIT] | r_reg.lock_s2);
		rf_src = div_tap(r_reg.div_sel, r_reg.div_cnt, r_reg.vco_s2);
		r_next.rf_p = rf_on & rf_src;
		r_next.rf_n = rf_on & ~rf_src;
		r_next.rf_level = r4_sh[psl_pkg::R4_LEVEL_LSB +: 2];

		mux_sel = r2_sh[psl_pkg::R2_MUX_LSB +: 3];
		r_next.mux_oe = 1'b1;
		unique case (mux_sel)
			psl_pkg::MUX_TRISTATE: begin
				r_next.mux_out = 1'b0;
				r_next.mux_oe = 1'b0;
			end
			psl_pkg::MUX_HIGH: r_next.mux_out = 1'b1;
			psl_pkg::MUX_LOW: r_next.mux_out = 1'b0;
			psl_pkg::MUX_REF_DIV: r_next.mux_out = r_reg.ref_s2;
			psl_pkg::MUX_FB_DIV: r_next.mux_out = r_reg.fb_s2;
			psl_pkg::MUX_ALOCK: r_next.mux_out = r_reg.lock_s2;
			psl_pkg::MUX_DLOCK: r_next.mux_out = r_reg.lock_s2;
			default: r_next.mux_out = 1'b0;
		endcase

		// Bus: one wait cycle, then the answer
		r_next.bus_ack = bus_req & ~r_reg.bus_ack;
		if (bus_req && !r_reg.bus_ack && avs_read) begin
			r_next.readdata = read_mux(avs_address, r_reg);
		end

		// A new event outranks a clear written in the same cycle
		r_next.irq_status = r_reg.irq_status;
		if (bus_fire && avs_write) begin
			if (avs_address == psl_pkg::ADDR_ENABLE) begin
				r_next.irq_enable = avs_writedata[IRQ_W_LOCAL-1:0];
			end
			if (avs_address == psl_pkg::ADDR_CLEAR) begin
				r_next.irq_status = r_reg.irq_status & ~avs_writedata[IRQ_W_LOCAL-1:0];
			end
		end
		r_next.irq_status = r_next.irq_status | ev;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign lock_indicator = r_reg.lock_out;
	assign selectable_test_output = r_reg.mux_out;
	assign selectable_test_output_oe = r_reg.mux_oe;
	assign pump_output_oe = r_reg.pump_oe;
	assign powered_up = r_reg.powered;
	assign rf_out_p = r_reg.rf_p;
	assign rf_out_n = r_reg.rf_n;
	assign rf_out_level = r_reg.rf_level;
	assign active_words = {r_reg.shadow[5], r_reg.shadow[4], r_reg.shadow[3],
		r_reg.act_r2, r_reg.act_r1, r_reg.shadow[0]};
	assign avs_readdata = r_reg.readdata;
	assign avs_waitrequest = bus_req & ~r_reg.bus_ack;
	assign irq = |(r_reg.irq_status & r_reg.irq_enable);

endmodule : psl_core

// [tb/psl_checker.sv]
`timescale 1ns/1ps
module psl_checker (
	input wire logic        clock,
	input wire logic        arst_n,
	input wire logic        chip_enable,
	input wire logic        rf_mute_n,
	input wire logic        loop_locked,
	input wire logic        lock_indicator,
	input wire logic        pump_output_oe,
	input wire logic        powered_up,
	input wire logic        rf_out_p,
	input wire logic        rf_out_n,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("second wait state");
	a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait without request");
	a_rdata_hold: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
		else $error("read data moved outside a read");
	a_lock_rise: assert property ($rose(loop_locked) |-> ##[1:5] lock_indicator)
		else $error("lock not shown");
	a_lock_fall: assert property ($fell(loop_locked) |-> ##[1:5] !lock_indicator)
		else $error("lock loss not shown");
	a_ce_down: assert property ($fell(chip_enable) |-> ##[1:5] !powered_up && !pump_output_oe)
		else $error("no power down");
	a_ce_held: assert property (!chip_enable [*6] |-> !pump_output_oe)
		else $error("pump driven while disabled");
	a_pin_mute: assert property (!rf_mute_n [*6] |-> !rf_out_p && !rf_out_n)
		else $error("RF not muted");
	a_rf_pair: assert property (rf_out_p |-> !rf_out_n)
		else $error("RF pair not complementary");
	c_read: cover property (avs_read && !avs_waitrequest);
	c_write: cover property (avs_write && !avs_waitrequest);
	c_irq: cover property ($rose(irq));
	c_lock: cover property ($rose(lock_indicator));
endmodule : psl_checker
bind psl_core psl_checker chk (.*);

// [tb/psl_host.sv]
`timescale 1ns/1ps
module psl_host (
	output logic serial_clk,
	output logic serial_data,
	output logic load_strobe
);
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		load_strobe = 1'b0;
	end
	// Link clock stands low between frames; data flips after use so nothing stale lingers
	task automatic send(input logic [31:0] w);
		#3;
		for (int i = 31; i >= 0; i--) begin
			serial_data = w[i];
			#16 serial_clk = 1'b1;
			#16 serial_clk = 1'b0;
		end
		#12 serial_data = ~w[0];
		#12 load_strobe = 1'b1;
		#32 load_strobe = 1'b0;
		#32;
	endtask : send
endmodule : psl_host

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic clock, arst_n, chip_enable, rf_mute_n, loop_locked, ref_div_in, fb_div_in, vco_in;
	logic avs_read, avs_write, avs_waitrequest, irq, lock_indicator, pump_output_oe, powered_up;
	logic selectable_test_output, selectable_test_output_oe, rf_out_p, rf_out_n;
	logic serial_clk, serial_data, load_strobe;
	logic [1:0]         rf_out_level;
	logic [7:0]         avs_address;
	logic [31:0]        avs_writedata, avs_readdata, q;
	psl_pkg::psl_bank_t active_words;
	int                 err_total, check_count, cycles;

	psl_core dut (.*);
	psl_host host (.*);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) if (++cycles > 30000) begin
		err_total++;
		test_done();
	end

	function automatic logic [31:0] wd(input int k);
		return 32'h5A3C_0000 | 32'(k * 257);
	endfunction : wd
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		// Settled at the falling edge; the answer is taken at the next rise
		do @(negedge clock); while (avs_waitrequest !== 1'b0);
		@(posedge clock);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(negedge clock);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask : rd
	task automatic bank;
		for (int k = 0; k < 6; k++) rd(8'(k * 4), wd(k));
	endtask : bank
	task automatic settle;
		repeat (8) @(posedge clock);
	endtask : settle
	// Double-buffered words need a trailing R0 write to take hold
	task automatic ld2(input logic [31:0] w);
		host.send(w);
		host.send(32'h0000_0000);
		settle();
	endtask : ld2
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	initial begin
		{arst_n, loop_locked, fb_div_in, vco_in, avs_read, avs_write} = '0;
		{chip_enable, rf_mute_n, ref_div_in} = 3'h7;
		avs_address = 8'h00;
		avs_writedata = 32'h0000_0000;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		rd(psl_pkg::ADDR_STATUS, 32'h0000_0000);
		rd(8'h3c, 32'h0000_0000);
		for (int i = 1; i < 6; i++) host.send(wd(i));
		settle();
		chk(active_words[1], 32'h0000_0000);
		host.send(wd(0));
		settle();
		chk(active_words[1], wd(1));
		chk(active_words[2], wd(2));
		rd(psl_pkg::ADDR_ACT_R1, wd(1));
		rd(psl_pkg::ADDR_ACT_R2, wd(2));
		bank();
		rd(psl_pkg::ADDR_SHIFT, wd(0));
		host.send(32'hFFFF_FFFE);
		host.send(32'hFFFF_FFFF);
		bank();
		bus(1'b0, psl_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(q & 32'h0000_0002, 32'h0000_0002);
		chk(irq, 1'b0);
		bus(1'b1, psl_pkg::ADDR_ENABLE, 32'h0000_0002);
		chk(irq, 1'b1);
		bus(1'b1, psl_pkg::ADDR_CLEAR, 32'h0000_0002);
		chk(irq, 1'b0);
		ld2(32'h0C00_0002);
		chk({powered_up, pump_output_oe}, 2'h3);
		ld2(32'h0C00_0022);
		chk({powered_up, pump_output_oe}, 2'h0);
		ld2(32'h0C00_0002);
		chk({powered_up, pump_output_oe}, 2'h3);
		chip_enable <= 1'b0;
		settle();
		chk({powered_up, pump_output_oe}, 2'h0);
		chip_enable <= 1'b1;
		for (int s = 0; s < 7; s++) begin
			loop_locked <= (s == 6);
			ld2(32'(s) << 26 | 32'h0000_0002);
			chk({selectable_test_output & (s != 0), selectable_test_output_oe},
				{s == 1 || s == 3 || s == 6, s != 0});
		end
		loop_locked <= 1'b0;
		host.send(32'h0000_0034);
		settle();
		chk(rf_out_level, 2'h2);
		chk(rf_out_p ^ rf_out_n, 1'b1);
		rf_mute_n <= 1'b0;
		settle();
		chk({rf_out_p, rf_out_n}, 2'h0);
		rf_mute_n <= 1'b1;
		host.send(32'h0000_0014);
		settle();
		chk({rf_out_p, rf_out_n}, 2'h0);
		loop_locked <= 1'b1;
		settle();
		chk(lock_indicator, 1'b1);
		loop_locked <= 1'b0;
		settle();
		chk(lock_indicator, 1'b0);
		bus(1'b0, psl_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(q & 32'h0000_000C, 32'h0000_000C);
		test_done();
	end
endmodule : testbench
